//--- include/dpadc_pkg.sv
package dpadc_pkg;

	// ************************************************************
	// Sizes and latency
	// ************************************************************
	localparam int NUM_CH              = 2;
	localparam int OUT_W               = 8;
	localparam int IN_W_DEF            = 12;
	localparam int PIPE_STAGES         = 6;
	localparam int BIT_W               = 2;
	localparam int CORR_BITS           = PIPE_STAGES * BIT_W;
	localparam int OUTPUT_LATENCY      = 6;
	localparam int TAG_SH              = 0;
	localparam int TAG_CORR            = OUTPUT_LATENCY - 1;
	localparam int FIFO_DEPTH_DEF      = 8;
	localparam int POWERUP_INVALID_CYC = 20;

	// ************************************************************
	// Stage decisions and output codes
	// ************************************************************
	localparam logic [1:0] B_LOW           = 2'h0;
	localparam logic [1:0] B_MID           = 2'h1;
	localparam logic [1:0] B_HIGH          = 2'h2;
	localparam logic [1:0] Q_L0            = 2'h0;
	localparam logic [1:0] Q_L1            = 2'h1;
	localparam logic [1:0] Q_L2            = 2'h2;
	localparam logic [1:0] Q_L3            = 2'h3;
	localparam logic [7:0] CODE_TOP        = 8'hFF;
	localparam logic [7:0] CODE_TOP_M1     = 8'hFE;
	localparam logic [7:0] CODE_ABOVE_ZERO = 8'h80;
	localparam logic [7:0] CODE_BELOW_ZERO = 8'h7F;
	localparam logic [7:0] CODE_BOTTOM_P1  = 8'h01;
	localparam logic [7:0] CODE_BOTTOM     = 8'h00;

	typedef enum logic {
		PH_SAMPLE = 1'b0,
		PH_HOLD   = 1'b1
	} dpadc_phase_t;

endpackage

//--- include/dpadc_stream_if.sv
`timescale 1ns/100ps
interface dpadc_stream_if #(
	parameter int W = 16
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- design/dpadc_fifo.sv
`timescale 1ns/100ps
module dpadc_fifo
	import dpadc_pkg::*;
#(
	parameter int W     = 16,
	parameter int DEPTH = FIFO_DEPTH_DEF
) (
	input wire logic    sys_clk,
	dpadc_stream_if.snk wr,
	dpadc_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("dpadc_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_ff  = '0;
	logic [AW-1:0] rp_ff  = '0;
	logic [AW:0]   cnt_ff = '0;
	logic [W-1:0]  out_ff = '0;
	logic          ov_ff  = 1'b0;
	logic          take;
	logic          push;
	logic          from_mem;
	logic          bypass;
	logic          wr_mem;

	// The output slot is a register so data leaves from flops; an empty
	// store lets a word skip straight into it without an extra cycle.
	assign take     = rd.ready | ~ov_ff;
	assign wr.ready = (cnt_ff != FULL_CNT);
	assign push     = wr.valid & wr.ready;
	assign from_mem = take & (cnt_ff != '0);
	assign bypass   = take & (cnt_ff == '0) & push;
	assign wr_mem   = push & ~bypass;
	assign rd.valid = ov_ff;
	assign rd.data  = out_ff;

	always_ff @(posedge sys_clk) begin
		if (wr_mem) begin
			mem[wp_ff] <= wr.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wr_mem) begin
			wp_ff <= wp_ff + 1'b1;
		end
		if (from_mem) begin
			rp_ff <= rp_ff + 1'b1;
		end
		cnt_ff <= cnt_ff + (AW + 1)'(wr_mem) - (AW + 1)'(from_mem);
	end

	always_ff @(posedge sys_clk) begin
		if (from_mem) begin
			out_ff <= mem[rp_ff];
		end else if (bypass) begin
			out_ff <= wr.data;
		end
		if (take) begin
			ov_ff <= from_mem | bypass;
		end
	end

endmodule // dpadc_fifo

//--- design/dpadc_top.sv
`timescale 1ns/100ps
module dpadc_top
	import dpadc_pkg::*;
#(
	parameter int IN_W       = IN_W_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input  wire logic             sys_clk,
	input  wire logic [IN_W-1:0]  i_channel_input_positive,
	input  wire logic [IN_W-1:0]  i_channel_input_negative,
	input  wire logic [IN_W-1:0]  q_channel_input_positive,
	input  wire logic [IN_W-1:0]  q_channel_input_negative,
	output wire logic [OUT_W-1:0] i_channel_output_bits,
	output wire logic [OUT_W-1:0] q_channel_output_bits,
	output wire logic             out_valid,
	input  wire logic             out_ready,
	output wire logic             word_accept,
	output wire logic             overrun,
	output wire logic             phi_sample,
	output wire logic             phi_hold
);
	// ************************************************************
	// Scaling
	// ************************************************************
	localparam int RW = IN_W + 2;
	localparam int FW = NUM_CH * OUT_W;
	localparam logic signed [RW-1:0] FS_POS  = RW'(1) <<< (IN_W - 1);
	localparam logic signed [RW-1:0] FS_NEG  = -FS_POS;
	localparam logic signed [RW-1:0] FS_MAXV = FS_POS - RW'(1);
	localparam logic signed [RW-1:0] QTR     = FS_POS >>> 2;
	localparam logic signed [RW-1:0] HALF    = FS_POS >>> 1;
	localparam logic signed [RW-1:0] LSB     = FS_POS >>> (OUT_W - 1);
	localparam logic signed [RW-1:0] LSB_H   = LSB >>> 1;
	localparam logic signed [RW-1:0] V_TOP1  = FS_POS - LSB - LSB_H;
	localparam logic signed [RW-1:0] V_BOT1  = FS_NEG + LSB + LSB_H;
	localparam logic signed [RW-1:0] V_ZERO  = RW'(0);

	if (IN_W < OUT_W + 2 || IN_W > 24) begin : g_chk
		$error("dpadc_top: IN_W must lie between OUT_W+2 and 24");
	end

	// ************************************************************
	// Arithmetic shared by every stage
	// ************************************************************
	function automatic logic signed [RW-1:0] clamp_diff(
		input logic [IN_W-1:0] p,
		input logic [IN_W-1:0] n
	);
		logic signed [RW-1:0] d;
		d = $signed(RW'(p)) - $signed(RW'(n));
		if (d > FS_MAXV) begin
			d = FS_MAXV;
		end else if (d < FS_NEG) begin
			d = FS_NEG;
		end
		return d;
	endfunction

	// One stage: three-level decision, so a wrong call by a quarter of
	// full scale still leaves the residue in range for the next stage.
	function automatic logic [RW+1:0] stage_res(
		input logic signed [RW-1:0] v
	);
		logic signed [RW-1:0] r;
		logic [1:0]           b;
		r = v <<< 1;
		b = B_MID;
		if (v >= QTR) begin
			b = B_HIGH;
			r = (v <<< 1) - FS_POS;
		end else if (v < -QTR) begin
			b = B_LOW;
			r = (v <<< 1) + FS_POS;
		end
		return {b, r};
	endfunction

	// Two stages in one clock: the second works on the first's residue
	// within the same cycle; the phase plays no part in either.
	function automatic logic [RW+3:0] pair_res(
		input logic signed [RW-1:0] v
	);
		logic [RW+1:0] s0;
		logic [RW+1:0] s1;
		s0 = stage_res(v);
		s1 = stage_res($signed(s0[RW-1:0]));
		return {s1[RW+:2], s0[RW+:2], s1[RW-1:0]};
	endfunction

	function automatic logic [1:0] flash_q(input logic signed [RW-1:0] v);
		logic [1:0] q;
		if (v >= HALF) begin
			q = Q_L3;
		end else if (v >= V_ZERO) begin
			q = Q_L2;
		end else if (v >= -HALF) begin
			q = Q_L1;
		end else begin
			q = Q_L0;
		end
		return q;
	endfunction

	// Weights of the overlapping stage bits; the offsets of the three
	// level codes cancel so the sum lands in offset binary directly.
	function automatic logic [OUT_W-1:0] correct(
		input logic [CORR_BITS-1:0] bits,
		input logic [1:0]           q
	);
		logic [OUT_W-1:0] acc;
		acc = OUT_W'(q);
		for (int i = 0; i < PIPE_STAGES; i++) begin
			acc = acc + (OUT_W'(bits[BIT_W*i+:BIT_W]) << (PIPE_STAGES - i));
		end
		return acc;
	endfunction

	// ************************************************************
	// Internal two-phase clock
	// ************************************************************
	dpadc_phase_t phase_ff = PH_SAMPLE;

	always_ff @(posedge sys_clk) begin
		unique case (phase_ff)
			PH_SAMPLE: phase_ff <= PH_HOLD;
			PH_HOLD:   phase_ff <= PH_SAMPLE;
		endcase
	end

	assign phi_sample = (phase_ff == PH_SAMPLE);
	assign phi_hold   = (phase_ff == PH_HOLD);

	// ************************************************************
	// Fill tracking
	// ************************************************************
	// No reset exists, so words are trusted only once a marker shifted
	// in behind power-up has walked the whole pipeline.
	logic [OUTPUT_LATENCY-1:0] tag_ff = '0;

	always_ff @(posedge sys_clk) begin
		tag_ff <= {tag_ff[OUTPUT_LATENCY-2:0], 1'b1};
	end

	// ************************************************************
	// Conversion channels
	// ************************************************************
	logic [NUM_CH-1:0][IN_W-1:0]  pin_pos;
	logic [NUM_CH-1:0][IN_W-1:0]  pin_neg;
	logic [NUM_CH-1:0][OUT_W-1:0] corr_all;

	assign pin_pos = {q_channel_input_positive, i_channel_input_positive};
	assign pin_neg = {q_channel_input_negative, i_channel_input_negative};

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		logic [IN_W-1:0]      pos_meta_ff = '0;
		logic [IN_W-1:0]      pos_sync_ff = '0;
		logic [IN_W-1:0]      neg_meta_ff = '0;
		logic [IN_W-1:0]      neg_sync_ff = '0;
		logic signed [RW-1:0] sh_ff       = '0;
		logic signed [RW-1:0] r1_ff       = '0;
		logic signed [RW-1:0] r2_ff       = '0;
		logic signed [RW-1:0] r3_ff       = '0;
		logic [3:0]           bits1_ff    = '0;
		logic [7:0]           bits2_ff    = '0;
		logic [CORR_BITS-1:0] bits3_ff    = '0;
		logic [CORR_BITS-1:0] bits4_ff    = '0;
		logic [1:0]           q4_ff       = '0;
		logic [OUT_W-1:0]     corr_ff     = '0;
		logic [RW+3:0]        nxt_p1;
		logic [RW+3:0]        nxt_p2;
		logic [RW+3:0]        nxt_p3;

		always_ff @(posedge sys_clk) begin
			pos_meta_ff <= pin_pos[ch];
			pos_sync_ff <= pos_meta_ff;
			neg_meta_ff <= pin_neg[ch];
			neg_sync_ff <= neg_meta_ff;
		end

		// The hold register loads on every rising edge, whatever the phase,
		// so a new sample is taken each cycle.
		always_ff @(posedge sys_clk) begin
			sh_ff <= clamp_diff(pos_sync_ff, neg_sync_ff);
		end

		always_comb begin
			nxt_p1 = pair_res(sh_ff);
			nxt_p2 = pair_res(r1_ff);
			nxt_p3 = pair_res(r2_ff);
		end

		// Earlier stage bits ride along with later ones, so the bits of
		// one sample meet the flash result in the same register.
		always_ff @(posedge sys_clk) begin
			r1_ff    <= $signed(nxt_p1[RW-1:0]);
			bits1_ff <= nxt_p1[RW+:4];
			r2_ff    <= $signed(nxt_p2[RW-1:0]);
			bits2_ff <= {nxt_p2[RW+:4], bits1_ff};
			r3_ff    <= $signed(nxt_p3[RW-1:0]);
			bits3_ff <= {nxt_p3[RW+:4], bits2_ff};
			bits4_ff <= bits3_ff;
			q4_ff    <= flash_q(r3_ff);
		end

		always_ff @(posedge sys_clk) begin
			corr_ff <= correct(bits4_ff, q4_ff);
		end

		assign corr_all[ch] = corr_ff;
	end

	// ************************************************************
	// Output buffer
	// ************************************************************
	dpadc_stream_if #(.W(FW)) push_if ();
	dpadc_stream_if #(.W(FW)) pop_if ();

	logic overrun_ff = 1'b0;

	assign push_if.valid = tag_ff[TAG_CORR];
	assign push_if.data  = corr_all;
	assign pop_if.ready  = out_ready;
	assign word_accept   = push_if.ready;

	// The converter cannot pause its sampling, so a word offered while
	// the buffer is full is lost and flagged for one cycle.
	always_ff @(posedge sys_clk) begin
		overrun_ff <= push_if.valid & ~push_if.ready;
	end

	dpadc_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk (sys_clk),
		.wr      (push_if),
		.rd      (pop_if)
	);

	assign overrun               = overrun_ff;
	assign out_valid             = pop_if.valid;
	assign i_channel_output_bits = pop_if.data[OUT_W-1:0];
	assign q_channel_output_bits = pop_if.data[FW-1:OUT_W];

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking

	property p_phase_alt;
		phi_sample |=> phi_hold && !phi_sample;
	endproperty
	a_phase_alt: assert property (p_phase_alt)
		else $error("sampling phase not followed by holding phase");

	property p_phase_back;
		phi_hold |=> phi_sample ##1 phi_hold;
	endproperty
	a_phase_back: assert property (p_phase_back)
		else $error("holding phase not followed by sampling phase");

	property p_latency;
		$rose(tag_ff[TAG_CORR]) |->
			$past(tag_ff[TAG_SH], 5) && !$past(tag_ff[TAG_SH], 6);
	endproperty
	a_latency: assert property (p_latency)
		else $error("first corrected word not five edges after capture");

	property p_end_to_end;
		(tag_ff[TAG_SH] && g_ch[0].sh_ff == FS_MAXV &&
			u_fifo.cnt_ff == '0 && out_ready) ##1 out_ready[*5]
			|=> out_valid && i_channel_output_bits == CODE_TOP;
	endproperty
	a_end_to_end: assert property (p_end_to_end)
		else $error("word did not reach the bus six cycles after capture");

	property p_stream;
		tag_ff[TAG_CORR] |=> out_valid;
	endproperty
	a_stream: assert property (p_stream)
		else $error("word stream broke after the latency");

	property p_top;
		g_ch[0].sh_ff == FS_MAXV |-> ##5 corr_all[0] == CODE_TOP;
	endproperty
	a_top: assert property (p_top)
		else $error("top input did not give all ones");

	property p_top1;
		g_ch[1].sh_ff == V_TOP1 |-> ##5 corr_all[1] == CODE_TOP_M1;
	endproperty
	a_top1: assert property (p_top1)
		else $error("one step below top gave wrong code");

	property p_mid;
		g_ch[0].sh_ff > V_ZERO && g_ch[0].sh_ff < LSB |->
			##5 corr_all[0] == CODE_ABOVE_ZERO;
	endproperty
	a_mid: assert property (p_mid)
		else $error("just above zero did not give 0x80");

	property p_mid_neg;
		g_ch[0].sh_ff < V_ZERO && g_ch[0].sh_ff >= -LSB |->
			##5 corr_all[0] == CODE_BELOW_ZERO;
	endproperty
	a_mid_neg: assert property (p_mid_neg)
		else $error("just below zero did not give 0x7F");

	property p_bottom;
		g_ch[1].sh_ff == FS_NEG |-> ##5 corr_all[1] == CODE_BOTTOM;
	endproperty
	a_bottom: assert property (p_bottom)
		else $error("bottom input did not give all zeros");

	property p_bottom1;
		g_ch[0].sh_ff == V_BOT1 |-> ##5 corr_all[0] == CODE_BOTTOM_P1;
	endproperty
	a_bottom1: assert property (p_bottom1)
		else $error("one step above bottom gave wrong code");

	property p_sign;
		tag_ff[TAG_SH] |->
			##5 corr_all[0][OUT_W-1] == !$past(g_ch[0].sh_ff[RW-1], 5);
	endproperty
	a_sign: assert property (p_sign)
		else $error("offset binary MSB does not follow input sign");

	property p_twins;
		g_ch[0].sh_ff == g_ch[1].sh_ff |-> ##5 corr_all[0] == corr_all[1];
	endproperty
	a_twins: assert property (p_twins)
		else $error("identical inputs gave different channel codes");

	property p_monotone;
		g_ch[0].sh_ff > g_ch[1].sh_ff |-> ##5 corr_all[0] >= corr_all[1];
	endproperty
	a_monotone: assert property (p_monotone)
		else $error("corrected code not monotonic in input");

	property p_no_early;
		!tag_ff[TAG_CORR] |-> !push_if.valid ##1 !out_valid;
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("word marked valid before the pipeline filled");

	c_first_word: cover property ($rose(out_valid));
	c_full: cover property (!word_accept);
	c_overrun: cover property (overrun ##1 word_accept);
	c_top_code: cover property (out_valid && i_channel_output_bits == CODE_TOP);

endmodule // dpadc_top

//--- tb/dpadc_capture_model.sv
`timescale 1ns/100ps
module dpadc_capture_model
	import dpadc_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             out_valid,
	input  wire logic [OUT_W-1:0] i_bits,
	input  wire logic [OUT_W-1:0] q_bits,
	input  wire logic             stall,
	output wire logic             out_ready
);
	// ************************************************************
	// Capture of both output buses
	// ************************************************************
	logic [OUT_W-1:0] cap_i[$];
	logic [OUT_W-1:0] cap_q[$];
	int               edge_cnt_ff = 0;
	logic             ready_ff    = 1'b0;
	logic             warm;

	assign out_ready = ready_ff;
	// Early words may be pipeline garbage, so they are never kept.
	assign warm      = (edge_cnt_ff >= POWERUP_INVALID_CYC);

	// Ready moves just after a rising edge, never inside a sampled cycle.
	always @(posedge sys_clk) begin
		ready_ff <= !stall;
	end

	always @(posedge sys_clk) begin
		edge_cnt_ff <= edge_cnt_ff + 1;
		if (out_valid && ready_ff && warm) begin
			cap_i.push_back(i_bits);
			cap_q.push_back(q_bits);
		end
	end
endmodule // dpadc_capture_model

//--- tb/dpadc_bench.sv
`timescale 1ns/100ps
module dpadc_bench
	import dpadc_pkg::*;
	;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	localparam int PIN_LAT = OUTPUT_LATENCY + 3;

	logic                sys_clk   = 1'b0;
	logic [IN_W_DEF-1:0] i_pos     = '0;
	logic [IN_W_DEF-1:0] i_neg     = '0;
	logic [IN_W_DEF-1:0] q_pos     = '0;
	logic [IN_W_DEF-1:0] q_neg     = '0;
	logic                stall     = 1'b0;
	wire  [OUT_W-1:0]    i_bits;
	wire  [OUT_W-1:0]    q_bits;
	wire                 out_valid;
	wire                 out_ready;
	wire                 word_accept;
	wire                 overrun;
	wire                 phi_sample;
	wire                 phi_hold;
	int                  bad_count = 0;
	int                  tests_run = 0;

	dpadc_top #(
		.IN_W       (IN_W_DEF),
		.FIFO_DEPTH (FIFO_DEPTH_DEF)
	) DUT (
		.sys_clk                  (sys_clk),
		.i_channel_input_positive (i_pos),
		.i_channel_input_negative (i_neg),
		.q_channel_input_positive (q_pos),
		.q_channel_input_negative (q_neg),
		.i_channel_output_bits    (i_bits),
		.q_channel_output_bits    (q_bits),
		.out_valid                (out_valid),
		.out_ready                (out_ready),
		.word_accept              (word_accept),
		.overrun                  (overrun),
		.phi_sample               (phi_sample),
		.phi_hold                 (phi_hold)
	);

	dpadc_capture_model cap (
		.sys_clk   (sys_clk),
		.out_valid (out_valid),
		.i_bits    (i_bits),
		.q_bits    (q_bits),
		.stall     (stall),
		.out_ready (out_ready)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic conclude();
		$display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check_word(input logic [OUT_W-1:0] got,
		input logic [OUT_W-1:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h want %h",
				$time, what, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp,
		input string what);
		check_word({7'h00, got}, {7'h00, exp}, what);
	endtask

	task automatic check_num(input int got, input int exp, input string what);
		tests_run++;
		if (got != exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %0d want %0d",
				$time, what, got, exp);
		end
	endtask

	function automatic logic [OUT_W-1:0] exp_code(input int d);
		int c;
		if (d > 2047) d = 2047;
		if (d < -2048) d = -2048;
		c = (d + 2048) / 16;
		return c[OUT_W-1:0];
	endfunction

	// Inputs change only at the falling edge, away from the sampling edge.
	task automatic drive(input int di, input int dq);
		int ni;
		int nq;
		ni = -di;
		nq = -dq;
		@(negedge sys_clk);
		i_pos = (di >= 0) ? di[IN_W_DEF-1:0] : '0;
		i_neg = (di < 0) ? ni[IN_W_DEF-1:0] : '0;
		q_pos = (dq >= 0) ? dq[IN_W_DEF-1:0] : '0;
		q_neg = (dq < 0) ? nq[IN_W_DEF-1:0] : '0;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_powerup();
		repeat (5) begin
			@(negedge sys_clk);
			check_bit(out_valid, 1'b0, "valid at power-up");
		end
		$display("Test power-up done");
	endtask

	task automatic t_phases();
		logic prev;
		@(negedge sys_clk);
		prev = phi_sample;
		repeat (8) begin
			@(negedge sys_clk);
			check_bit(phi_hold, !phi_sample, "phase overlap");
			check_bit(phi_sample, !prev, "phase toggle");
			prev = phi_sample;
		end
		$display("Test phases done");
	endtask

	task automatic t_codes();
		int               dt[10] = '{2047, 2024, 15, 0, -1, -16, -2024,
			-2048, 4095, -4095};
		logic [OUT_W-1:0] ex[10] = '{CODE_TOP, CODE_TOP_M1, CODE_ABOVE_ZERO,
			CODE_ABOVE_ZERO, CODE_BELOW_ZERO, CODE_BELOW_ZERO, CODE_BOTTOM_P1,
			CODE_BOTTOM, CODE_TOP, CODE_BOTTOM};
		for (int k = 0; k < 10; k++) begin
			drive(dt[k], -dt[k]);
			repeat (PIN_LAT + 3) @(negedge sys_clk);
			check_bit(out_valid, 1'b1, "valid");
			check_word(i_bits, ex[k], "I code");
			check_word(q_bits, exp_code(-dt[k]), "Q code");
		end
		$display("Test code table done");
	endtask

	task automatic t_latency();
		int               n;
		logic [OUT_W-1:0] seq;
		drive(-2048, -2048);
		repeat (PIN_LAT + 3) @(negedge sys_clk);
		drive(2047, 2047);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (i_bits !== CODE_TOP && n < 30);
		if (n >= 30) begin
			bad_count++;
			conclude();
		end
		check_num(n, PIN_LAT, "latency");
		check_word(q_bits, CODE_TOP, "Q in step");
		for (int k = 0; k < 8; k++) begin
			drive(256 * (k + 1) - 2048, 256 * (k + 1) - 2048);
		end
		repeat (PIN_LAT - 7) @(negedge sys_clk);
		for (int k = 0; k < 8; k++) begin
			seq = OUT_W'(16 * (k + 1));
			check_word(i_bits, seq, "stream word");
			@(negedge sys_clk);
		end
		$display("Test latency done");
	endtask

	// The pipeline pushes every cycle, so a stall overfills the buffer.
	task automatic t_overrun();
		int               ovr   = 0;
		int               full  = 0;
		int               jumps = 0;
		int               gap   = 0;
		logic [OUT_W-1:0] held;
		for (int k = 0; k < 60; k++) begin
			drive(16 * k - 1536, 16 * k - 1536);
			if (k == 10) stall = 1'b1;
			if (k == 25) stall = 1'b0;
			if (k == 12) begin
				cap.cap_i.delete();
				cap.cap_q.delete();
				held = i_bits;
			end
			if (k == 24) check_word(i_bits, held, "held word");
			if (overrun === 1'b1) ovr++;
			if (word_accept === 1'b0) full++;
		end
		for (int i = 0; i + 1 < cap.cap_i.size(); i++) begin
			check_word(cap.cap_q[i], cap.cap_i[i], "I/Q pairing");
			if (cap.cap_i[i + 1] !== cap.cap_i[i] + 1'b1) begin
				jumps++;
				gap = int'(cap.cap_i[i + 1]) - int'(cap.cap_i[i]) - 1;
			end
		end
		check_num(jumps, 1, "drop runs");
		check_num(gap, ovr, "overrun pulses");
		check_bit(full != 0, 1'b1, "buffer full");
		$display("Test overrun done");
	endtask

	// ************************************************************
	// Clock and main sequence
	// ************************************************************
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	initial begin
		t_powerup();
		repeat (POWERUP_INVALID_CYC) @(negedge sys_clk);
		t_phases();
		t_codes();
		t_latency();
		t_overrun();
		conclude();
	end
endmodule // dpadc_bench
